// ===== src/cab_counter_capture_regs.sv
// Counter and capture/compare byte registers of the second counter array.
// Assumes single-cycle SFR strobes on clk_in; the page register, PWM control
// and mode registers live elsewhere and arrive as inputs.
`timescale 1ns/1ps
`include "cab_map.svh"

module cab_counter_capture_regs
(
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rstn_in,
  // Special-function register bus
  input  wire cab_pkg::cab_sfr_req_type sfr_req_in,
  output logic [7:0]                    sfr_rdata_out,
  output logic                          sfr_hit_out,
  // Counter run control and PWM control bits
  input  wire logic                     count_enable_in,
  input  wire cab_pkg::cab_pwm_ctl_type pwm_ctl_in,
  input  wire logic [5:0]               wide_pwm_select_in,
  input  wire logic [5:0]               pwm_enable_in,
  // Module state toward the compare logic
  output logic [15:0]                   array_counter_out,
  output logic [5:0]                    comparator_enable_out,
  output logic [5:0]                    compare_match_out,
  output logic [5:0]                    cycle_wrap_out
);

  logic [15:0] counter;
  logic [7:0]  snapshot;
  logic [5:0]  comparator_enable;
  logic [15:0] module_value [6];
  logic [15:0] reload_value [6];
  logic        page_ok;
  logic        wr_cnt_low;
  logic        wr_cnt_high;
  logic        rd_cnt_low;
  logic [5:0]  wr_low;
  logic [5:0]  wr_high;
  logic [5:0]  sel_low;
  logic [5:0]  sel_high;
  logic [15:0] cycle_mask;
  logic [15:0] next_counter;
  logic [7:0]  next_rdata;

  localparam logic [7:0] LOW_ADDR  [6] = '{`CAB_ADDR_LOW_6, `CAB_ADDR_LOW_7,
    `CAB_ADDR_LOW_8, `CAB_ADDR_LOW_9, `CAB_ADDR_LOW_10, `CAB_ADDR_LOW_11};
  localparam logic [7:0] HIGH_ADDR [6] = '{`CAB_ADDR_HIGH_6, `CAB_ADDR_HIGH_7,
    `CAB_ADDR_HIGH_8, `CAB_ADDR_HIGH_9, `CAB_ADDR_HIGH_10, `CAB_ADDR_HIGH_11};

  assign page_ok     = (sfr_req_in.page == `CAB_PAGE);
  assign wr_cnt_low  = page_ok & sfr_req_in.wr & (sfr_req_in.addr == `CAB_ADDR_CNT_LOW);
  assign wr_cnt_high = page_ok & sfr_req_in.wr & (sfr_req_in.addr == `CAB_ADDR_CNT_HIGH);
  assign rd_cnt_low  = page_ok & sfr_req_in.rd & (sfr_req_in.addr == `CAB_ADDR_CNT_LOW);

  // Period mask for 8 to 11-bit PWM
  always_comb
  begin
    case (cab_pkg::cab_len_type'(pwm_ctl_in.cycle_len))
      cab_pkg::CAB_LEN_8:  cycle_mask = 16'h00ff;
      cab_pkg::CAB_LEN_9:  cycle_mask = 16'h01ff;
      cab_pkg::CAB_LEN_10: cycle_mask = 16'h03ff;
      cab_pkg::CAB_LEN_11: cycle_mask = 16'h07ff;
      default:             cycle_mask = 16'h00ff;
    endcase
  end

  always_comb
  begin
    next_counter = counter;
    if (count_enable_in)
    begin
      next_counter = counter + 16'h0001;
    end
    if (wr_cnt_low)
    begin
      next_counter[7:0] = sfr_req_in.wdata;
    end
    if (wr_cnt_high)
    begin
      next_counter[15:8] = sfr_req_in.wdata;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      counter <= `CAB_RESET_WORD;
    end
    else
    begin
      counter <= next_counter;
    end
  end

  // Upper byte frozen on a low byte read so low-then-high reads agree
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      snapshot <= `CAB_RESET_BYTE;
    end
    else if (rd_cnt_low)
    begin
      snapshot <= counter[15:8];
    end
  end

  genvar i;
  generate
    for (i = 0; i < 6; i++)
    begin : g_module
      assign sel_low[i]  = page_ok & (sfr_req_in.addr == LOW_ADDR[i]);
      assign sel_high[i] = page_ok & (sfr_req_in.addr == HIGH_ADDR[i]);
      assign wr_low[i]   = sel_low[i] & sfr_req_in.wr;
      assign wr_high[i]  = sel_high[i] & sfr_req_in.wr;

      always_ff @(posedge clk_in)
      begin
        if (!rstn_in)
        begin
          module_value[i] <= `CAB_RESET_WORD;
          reload_value[i] <= `CAB_RESET_WORD;
        end
        else if (pwm_ctl_in.reload_sel)
        begin
          if (wr_low[i])
          begin
            reload_value[i][7:0] <= sfr_req_in.wdata;
          end
          if (wr_high[i])
          begin
            reload_value[i][15:8] <= sfr_req_in.wdata;
          end
        end
        else
        begin
          if (wr_low[i])
          begin
            module_value[i][7:0] <= sfr_req_in.wdata;
          end
          if (wr_high[i])
          begin
            module_value[i][15:8] <= sfr_req_in.wdata;
          end
        end
      end

      // Enable side effect applies whichever storage the write reached
      always_ff @(posedge clk_in)
      begin
        if (!rstn_in)
        begin
          comparator_enable[i] <= 1'b0;
        end
        else if (wr_high[i])
        begin
          comparator_enable[i] <= 1'b1;
        end
        else if (wr_low[i])
        begin
          comparator_enable[i] <= 1'b0;
        end
      end

      // 16-bit PWM compares all bits; narrower modes compare within the period
      always_ff @(posedge clk_in)
      begin
        if (!rstn_in)
        begin
          compare_match_out[i] <= 1'b0;
        end
        else if (pwm_enable_in[i] && !wide_pwm_select_in[i])
        begin
          compare_match_out[i] <= comparator_enable[i] &&
            ((counter & cycle_mask) == (module_value[i] & cycle_mask));
        end
        else
        begin
          compare_match_out[i] <= comparator_enable[i] &&
            (counter == module_value[i]);
        end
      end

      always_ff @(posedge clk_in)
      begin
        if (!rstn_in)
        begin
          cycle_wrap_out[i] <= 1'b0;
        end
        else
        begin
          cycle_wrap_out[i] <= count_enable_in && pwm_enable_in[i] &&
            !wide_pwm_select_in[i] && ((counter & cycle_mask) == cycle_mask);
        end
      end
    end
  endgenerate

  // Read data mux
  always_comb
  begin
    next_rdata = `CAB_RESET_BYTE;
    if (page_ok && (sfr_req_in.addr == `CAB_ADDR_CNT_LOW))
    begin
      next_rdata = counter[7:0];
    end
    if (page_ok && (sfr_req_in.addr == `CAB_ADDR_CNT_HIGH))
    begin
      next_rdata = snapshot;
    end
    for (int k = 0; k < 6; k++)
    begin
      if (sel_low[k])
      begin
        next_rdata = pwm_ctl_in.reload_sel ? reload_value[k][7:0] : module_value[k][7:0];
      end
      if (sel_high[k])
      begin
        next_rdata = pwm_ctl_in.reload_sel ? reload_value[k][15:8] : module_value[k][15:8];
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      sfr_rdata_out <= `CAB_RESET_BYTE;
    end
    else if (sfr_req_in.rd)
    begin
      sfr_rdata_out <= next_rdata;
    end
  end

  assign sfr_hit_out           = page_ok & ((|sel_low) | (|sel_high) |
    (sfr_req_in.addr == `CAB_ADDR_CNT_LOW) | (sfr_req_in.addr == `CAB_ADDR_CNT_HIGH));
  assign array_counter_out     = counter;
  assign comparator_enable_out = comparator_enable;

endmodule : cab_counter_capture_regs

// ===== src/cab_map.svh
// Register map constants for the counter array register front end.
// Assumes an 8-bit special-function register bus with a page register outside.
// Behaviour
// - The counter low byte (bits 7:0) is read and written at address 0xf9.
// - The counter high byte (bits 15:8) sits at 0xfa and a write loads the upper half.
// - Reading the high byte returns a snapshot of the upper byte taken when the low byte is read.
// - Both counter bytes live on page 0x10 and reset to zero.
// - Each of modules 6 to 11 holds its value low byte at its own address (0xfb, 0xe9 .. 0xce).
// - Each of modules 6 to 11 holds its value high byte at its own address (0xfc, 0xea .. 0xcf).
// - The same module addresses also reach the channel auto-reload value for 9 to 11-bit PWM.
// - One reload access select bit picks between the module value and the auto-reload value.
// - Any write to a module low byte clears that module's comparator enable.
// - Any write to a module high byte sets that module's comparator enable.
// - All twelve module bytes live on page 0x10, are read/write and reset to zero.
// - A set comparator enable enables comparing the counter against the module value.
// - A two-bit cycle length field picks an 8, 9, 10 or 11-bit period; 16-bit channels ignore it.
// - A per-module wide PWM select picks 16-bit PWM when 1 and 8 to 11-bit PWM when 0.
`ifndef CAB_MAP_SVH
`define CAB_MAP_SVH

`define CAB_PAGE          8'h10
`define CAB_ADDR_CNT_LOW  8'hf9
`define CAB_ADDR_CNT_HIGH 8'hfa
`define CAB_ADDR_LOW_6    8'hfb
`define CAB_ADDR_HIGH_6   8'hfc
`define CAB_ADDR_LOW_7    8'he9
`define CAB_ADDR_HIGH_7   8'hea
`define CAB_ADDR_LOW_8    8'heb
`define CAB_ADDR_HIGH_8   8'hec
`define CAB_ADDR_LOW_9    8'hed
`define CAB_ADDR_HIGH_9   8'hee
`define CAB_ADDR_LOW_10   8'hfd
`define CAB_ADDR_HIGH_10  8'hfe
`define CAB_ADDR_LOW_11   8'hce
`define CAB_ADDR_HIGH_11  8'hcf
`define CAB_RESET_BYTE    8'h00
`define CAB_RESET_WORD    16'h0000

`endif

// ===== src/cab_pkg.sv
// Types shared by the counter array register front end.
// Assumes cab_map.svh supplies the numeric constants.
package cab_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] page;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cab_sfr_req_type;

  typedef struct packed {
    logic       reload_sel;
    logic [1:0] cycle_len;
  } cab_pwm_ctl_type;

  typedef enum logic [1:0] {
    CAB_LEN_8,
    CAB_LEN_9,
    CAB_LEN_10,
    CAB_LEN_11
  } cab_len_type;
endpackage : cab_pkg

// ===== tb/cab_regs_asserts.sv
// Assertions on the counter array register front end.
// Assumes it is bound to cab_counter_capture_regs and sees only its ports.
`timescale 1ns/1ps

module cab_regs_asserts
(
  // Clock and reset
  input wire logic                     clk_in,
  input wire logic                     rstn_in,
  // Watched ports
  input wire cab_pkg::cab_sfr_req_type sfr_req_in,
  input wire logic [7:0]               sfr_rdata_out,
  input wire logic                     sfr_hit_out,
  input wire logic                     count_enable_in,
  input wire logic [15:0]              array_counter_out,
  input wire logic [5:0]               comparator_enable_out
);
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = sfr_req_in.wr && sfr_req_in.page == 8'h10;
  assign rd_ok = sfr_req_in.rd && sfr_req_in.page == 8'h10;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  chk_low_clears_en : assert property (
    wr_ok && sfr_req_in.addr == 8'hfb |=> !comparator_enable_out[0]) else $error("enable kept");
  chk_high_sets_en : assert property (
    wr_ok && sfr_req_in.addr == 8'hcf |=> comparator_enable_out[5]) else $error("enable unset");
  chk_enable_holds : assert property (
    !sfr_req_in.wr |=> $stable(comparator_enable_out)) else $error("enable moved");
  chk_cnt_low_load : assert property (
    wr_ok && sfr_req_in.addr == 8'hf9
    |=> array_counter_out[7:0] == $past(sfr_req_in.wdata)) else $error("low not loaded");
  chk_cnt_high_load : assert property (
    wr_ok && sfr_req_in.addr == 8'hfa
    |=> array_counter_out[15:8] == $past(sfr_req_in.wdata)) else $error("high not loaded");
  chk_snapshot_read : assert property (
    rd_ok && sfr_req_in.addr == 8'hf9 ##1 rd_ok && sfr_req_in.addr == 8'hfa
    |=> sfr_rdata_out == $past(array_counter_out[15:8], 2)) else $error("bad snapshot");
  chk_reset_zero : assert property (
    $rose(rstn_in) |-> array_counter_out == 16'h0000 && comparator_enable_out == 6'h00)
    else $error("not zero after reset");
  chk_page_refused : assert property (
    sfr_req_in.rd && !rd_ok |-> !sfr_hit_out ##1 sfr_rdata_out == 8'h00)
    else $error("foreign page answered");
  chk_count_step : assert property (
    count_enable_in && !sfr_req_in.wr
    |=> array_counter_out == $past(array_counter_out) + 16'h0001) else $error("bad count");

  cov_snapshot : cover property (rd_ok && sfr_req_in.addr == 8'hf9 ##1 rd_ok);
  cov_enable_set : cover property ($rose(comparator_enable_out[0]));
  cov_counting : cover property (count_enable_in [*4]);
endmodule : cab_regs_asserts

bind cab_counter_capture_regs cab_regs_asserts chk (.clk_in, .rstn_in, .sfr_req_in,
  .sfr_rdata_out, .sfr_hit_out, .count_enable_in, .array_counter_out, .comparator_enable_out);

// ===== tb/tb_cab_counter_capture_regs.sv
// Self-checking bench for the counter array register front end.
// Assumes the checker is bound in; per-module PWM mode inputs stay at zero outside the narrow PWM test.
`timescale 1ns/1ps

module tb_cab_counter_capture_regs;
  logic                     clk_in;
  logic                     rstn_in;
  cab_pkg::cab_sfr_req_type req;
  cab_pkg::cab_pwm_ctl_type pwm_ctl;
  logic [7:0]               rdata;
  logic                     hit;
  logic                     cnt_en;
  logic [15:0]              counter;
  logic [5:0]               cmp_en;
  logic [5:0]               match;
  logic [5:0]               wide_sel;
  logic [5:0]               pwm_en;
  logic [5:0]               wrap;
  int                       failures;
  int                       compares;
  int                       n;
  logic [7:0]               lo [6] = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hce};
  logic [7:0]               hi [6] = '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hcf};

  cab_counter_capture_regs dut (.clk_in(clk_in), .rstn_in(rstn_in), .sfr_req_in(req),
    .sfr_rdata_out(rdata), .sfr_hit_out(hit), .count_enable_in(cnt_en),
    .pwm_ctl_in(pwm_ctl), .wide_pwm_select_in(wide_sel), .pwm_enable_in(pwm_en),
    .array_counter_out(counter), .comparator_enable_out(cmp_en),
    .compare_match_out(match), .cycle_wrap_out(wrap));

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [7:0] d);
    req = '{a, 8'h10, 1'b1, 1'b0, d};
    @(posedge clk_in);
    #1;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    req = '{a, 8'h10, 1'b0, 1'b1, 8'h00};
    @(posedge clk_in);
    #1;
    check(name, {8'h00, exp}, {8'h00, rdata});
  endtask : rd

  task conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    rstn_in = 1'b0;
    req = '0;
    pwm_ctl = '0;
    cnt_en = 1'b0;
    wide_sel = 6'h00;
    pwm_en = 6'h00;
    failures = 0;
    compares = 0;
    repeat (4) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    @(posedge clk_in);
    #1;
    rd(8'hf9, 8'h00, "counter low");
    rd(8'hfa, 8'h00, "counter high");
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 6; i++)
      begin
        pwm_ctl.reload_sel = s[0];
        rd(lo[i], 8'h00, "reset low");
        rd(hi[i], 8'h00, "reset high");
      end
    $display("test reset values done");
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 6; i++)
      begin
        pwm_ctl.reload_sel = s[0];
        wr(lo[i], 8'h30 + 8'(i) + 8'(s * 32));
        check("enable after low", 16'h0000, {15'h0, cmp_en[i]});
        wr(hi[i], 8'hc0 + 8'(i) + 8'(s * 32));
        check("enable after high", 16'h0001, {15'h0, cmp_en[i]});
      end
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 6; i++)
      begin
        pwm_ctl.reload_sel = s[0];
        rd(lo[i], 8'h30 + 8'(i) + 8'(s * 32), "module low");
        rd(hi[i], 8'hc0 + 8'(i) + 8'(s * 32), "module high");
      end
    pwm_ctl = '0;
    $display("test module bytes done");
    wr(8'hf9, 8'hfe);
    wr(8'hfa, 8'h12);
    rd(8'hf9, 8'hfe, "counter low");
    rd(8'hfa, 8'h12, "snapshot");
    wr(8'hfa, 8'h34);
    rd(8'hfa, 8'h12, "stale snapshot");
    rd(8'hf9, 8'hfe, "counter low");
    rd(8'hfa, 8'h34, "counter high");
    $display("test counter snapshot done");
    wr(8'hfb, 8'h05);
    wr(8'hfc, 8'h35);
    req = '0;
    cnt_en = 1'b1;
    n = 0;
    while (match[0] !== 1'b1 && n < 20)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("compare match", 16'h0001, {15'h0, match[0]});
    if (match[0] !== 1'b1)
      conclude();
    cnt_en = 1'b0;
    $display("test compare done");
    // Narrow 9-bit period: match on the masked value, then a wrap at 0x1ff
    wr(8'hf9, 8'hf0);
    wr(8'hfa, 8'h00);
    wr(8'hfb, 8'h05);
    wr(8'hfc, 8'h35);
    req = '0;
    pwm_ctl.cycle_len = 2'h1;
    pwm_en = 6'h01;
    cnt_en = 1'b1;
    n = 0;
    while (match[0] !== 1'b1 && n < 40)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("narrow match", 16'h0105, counter - 16'h0001);
    n = 0;
    while (wrap[0] !== 1'b1 && n < 300)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("cycle wrap", 16'h0200, counter);
    wide_sel = 6'h01;
    @(posedge clk_in);
    #1;
    n = 0;
    while (match[0] !== 1'b1 && n < 300)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("wide ignores length", 16'h0000, {15'h0, match[0]});
    cnt_en = 1'b0;
    pwm_en = 6'h00;
    wide_sel = 6'h00;
    pwm_ctl = '0;
    $display("test narrow pwm done");
    req = '{8'hf9, 8'h0f, 1'b0, 1'b1, 8'h00};
    #1;
    check("foreign hit", 16'h0000, {15'h0, hit});
    @(posedge clk_in);
    #1;
    check("foreign read", 16'h0000, {8'h00, rdata});
    rd(8'hd0, 8'h00, "unmapped read");
    $display("test refused access done");
    conclude();
  end
endmodule : tb_cab_counter_capture_regs
